// *** logic/stss_regs.svh ***
/*
  Constants of the target selection status reporter: interrupt codes,
  sequence step codes, message length limits and message byte fields.
  Assumes it is included by bare name from the length checker and the top module.
*/
`ifndef STSS_REGS_SVH
`define STSS_REGS_SVH

// ----------------------------------------------------------------------
// Interrupt codes
// ----------------------------------------------------------------------
`define STSS_CODE_LONG      8'h67
`define STSS_CODE_SEL       8'h80
`define STSS_CODE_SEL_ATN   8'h81
`define STSS_CODE_NO_ATN    8'hA0
`define STSS_CODE_MSG       8'hA1
`define STSS_CODE_BAD_IDENT 8'hA2
`define STSS_CODE_IDENT_MSG 8'hA3
`define STSS_CODE_BAD_CDB   8'hA4
`define STSS_CODE_IDENT_BAD 8'hA5
`define STSS_CODE_CDB       8'hA6
`define STSS_CODE_IDENT_CDB 8'hA7
`define STSS_CODE_CDB_MSG   8'hA8

// ----------------------------------------------------------------------
// Sequence step codes
// ----------------------------------------------------------------------
`define STSS_STEP_00        8'h00
`define STSS_STEP_81        8'h81
`define STSS_STEP_82        8'h82
`define STSS_STEP_83        8'h83
`define STSS_STEP_84        8'h84
`define STSS_STEP_92        8'h92
`define STSS_STEP_93        8'h93
`define STSS_STEP_A2        8'hA2
`define STSS_STEP_A3        8'hA3
`define STSS_STEP_B1        8'hB1
`define STSS_STEP_B2        8'hB2
`define STSS_STEP_B4        8'hB4

// ----------------------------------------------------------------------
// Message fields and length limits
// ----------------------------------------------------------------------
`define STSS_LIMIT_LONG     9'h021
`define STSS_LIMIT_IDENT    9'h003
`define STSS_MSG_EXTENDED   8'h01
`define STSS_IDENT_BIT      7
`define STSS_IDENT_RSVD     8'h18

`endif

// *** logic/stss_pkg.sv ***
/*
  Types of the target selection status reporter: sequencer states and
  the packed state record of the top module.
  Assumes nothing beyond the constants header.
*/
package stss_pkg;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,  // Waiting for selection
    ST_MSG1 = 6'h02,  // Message out right after selection
    ST_MSG2 = 6'h04,  // Message out after Identify
    ST_CMD  = 6'h08,  // Command block
    ST_MSG3 = 6'h10,  // Message out after command block
    ST_RPT  = 6'h20   // Result held for the host
  } stss_state_t;

  // All state of the top module except the reset release flip-flops
  typedef struct packed {
    stss_state_t st;       // Sequencer state
    logic [8:0]  cnt;      // Byte index within message or block
    logic [7:0]  first;    // First byte of current unit
    logic [7:0]  len;      // Length byte of extended message
    logic        ident;    // Identify already taken
    logic [7:0]  code;     // Interrupt code
    logic [7:0]  step;     // Sequence step code
    logic        valid;    // Result pending
    logic        atn_s1;   // ATN synchroniser, first stage
    logic        atn_s2;   // ATN synchroniser, second stage
  } stss_regs_t;

endpackage

// *** logic/stss_len_if.sv ***
/*
  Carrier between the sequencer and the message length checker.
  Assumes both ends sit on the same clock; the checker is combinational.
*/
`timescale 1ns/1ps

interface stss_len_if;
  logic [7:0] first_b;   // First byte of the message
  logic [7:0] len_b;     // Extended length byte
  logic [8:0] cnt;       // Index of the byte now taken
  logic [8:0] limit;     // Length at which a message counts as long
  logic       last;      // Byte now taken ends the message
  logic       too_long;  // Message reaches the limit

  modport seq  (output first_b, len_b, cnt, limit, input last, too_long);
  modport calc (input first_b, len_b, cnt, limit, output last, too_long);
endinterface

// *** logic/stss_msg_len.sv ***
/*
  Message length checker: works out the total length of a message from
  its first and length bytes, flags its last byte and a too long message.
  Assumes index and bytes are presented in the cycle the byte is taken.
*/
`timescale 1ns/1ps
`include "stss_regs.svh"

module stss_msg_len (
  stss_len_if.calc lif  // Length query from the sequencer
);

  // --------------------------------------------------------------------
  // Length decode
  // --------------------------------------------------------------------

  // Total length of a message from its leading bytes
  function automatic logic [8:0] msg_total(input logic [7:0] f, input logic [7:0] l);
    if (f == `STSS_MSG_EXTENDED)
      msg_total = (l == 8'h00) ? 9'h102 : {1'b0, l} + 9'h002;
    else if (f[7:4] == 4'h2)
      msg_total = 9'h002;
    else
      msg_total = 9'h001;
  endfunction

  logic       ext;    // Extended message
  logic [8:0] total;  // Total length in bytes

  // Flags for the byte now taken
  always_comb
  begin
    ext   = (lif.first_b == `STSS_MSG_EXTENDED);
    total = msg_total(lif.first_b, lif.len_b);
    if (ext)
      lif.last = (lif.cnt != 9'h000) && (lif.cnt == total - 9'h001);
    else
      lif.last = (lif.cnt == total - 9'h001);
    lif.too_long = ext && (lif.cnt == 9'h001) && (total >= lif.limit);
  end

endmodule

// *** logic/stss_top.sv ***
/*
  Target selection response sequencer with status reporting. Follows the
  message and command bytes after selection and ends with an interrupt
  code and sequence step code held for the host.
  Assumes bytes arrive from bus handshake logic on CORE_CLK; ATN is a
  pin and is synchronised here.
  // Overview of operation
  // (RULE1) Long first message: two bytes, 67h/81h
  // (RULE2) Long message after Identify: 67h/82h
  // (RULE3) Identify, block, long message: 67h/93h
  // (RULE4) Auto receive, block, long message: 67h/B2h
  // (RULE5) No auto response: 80h/00h, 81h with ATN
  // (RULE6) Message-only setting, no ATN: A0h/81h
  // (RULE7) Non-Identify message: A1h, step A2h/A3h
  // (RULE8) Illegal Identify: A2h, step 92h/82h
  // (RULE9) Identify plus message: A3h, step 83h/84h
  // (RULE10) Undefined first opcode: one byte, A4h/B1h
  // (RULE11) Identify, undefined block: one byte, A5h/92h
  // (RULE12) Block A6h/B2h; Identify plus block A7h/93h
  // (RULE13) Auto receive message: A8h, step B1h/B4h
  // (RULE14) Auto response on: continue, no early stop
  // (RULE15) Auto receive on: message after block ATN
  // (RULE16) Phase setting: message/command or message only
  // (RULE17) Codes held together until host read
*/
`timescale 1ns/1ps
`include "stss_regs.svh"

module stss_top (
  input  wire logic       CORE_CLK,       // 40 MHz clock
  input  wire logic       ARST_N,         // Asynchronous reset, low
  input  wire logic       AUTO_SEL_RESP,  // Automatic selection response on
  input  wire logic       AUTO_RECV,      // Automatic receive mode on
  input  wire logic       MSG_ONLY,       // Message only setting: command phase only after Identify without ATN
  input  wire logic       SELECTED,       // Selected as target, pulse
  input  wire logic       ATN,            // ATN from the bus pin
  input  wire logic       RX_VALID,       // Byte offered by bus logic
  input  wire logic [7:0] RX_DATA,        // Offered byte
  input  wire logic       CODE_RD,        // Host has read the codes, pulse
  output logic            RX_TAKE,        // Ready to accept a byte
  output logic            PHASE_MSG_OUT,  // Message out phase requested
  output logic            PHASE_CMD,      // Command phase requested
  output logic [7:0]      INT_CODE,       // Interrupt code
  output logic [7:0]      SEQ_STEP,       // Sequence step code
  output logic            INT_VALID       // Codes pending for the host
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic rst_s1;  // Reset release, first stage
  logic rst_n;   // Reset for the design

  // Release the reset through two flip-flops
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  localparam stss_pkg::stss_regs_t RST_VAL = '{
    st: stss_pkg::ST_IDLE, cnt: 9'h000, first: 8'h00, len: 8'h00,
    ident: 1'b0, code: `STSS_STEP_00, step: `STSS_STEP_00, valid: 1'b0,
    atn_s1: 1'b0, atn_s2: 1'b0};

  // Command block length from its opcode group, zero when undefined
  function automatic logic [3:0] cdb_len(input logic [7:0] op);
    case (op[7:5])
      3'h0:    cdb_len = 4'h6;
      3'h1:    cdb_len = 4'hA;
      3'h2:    cdb_len = 4'hA;
      3'h5:    cdb_len = 4'hC;
      default: cdb_len = 4'h0;
    endcase
  endfunction

  // Stop the sequence and post a code pair
  function automatic stss_pkg::stss_regs_t report(input stss_pkg::stss_regs_t s,
                                                  input logic [7:0] c,
                                                  input logic [7:0] p);
    report       = s;
    report.st    = stss_pkg::ST_RPT;
    report.code  = c;
    report.step  = p;
    report.valid = 1'b1;
  endfunction

  // --------------------------------------------------------------------
  // State and length checker
  // --------------------------------------------------------------------
  stss_pkg::stss_regs_t r_r;    // Registered state
  stss_pkg::stss_regs_t r_nxt;  // Next state
  stss_len_if           lif (); // Length query carrier
  logic                 take;   // Byte taken this cycle
  logic                 atn;    // Synchronised ATN
  logic [3:0]           blen;   // Length of current command block

  stss_msg_len u_len (
    .lif (lif)
  );

  // Feed the length checker with the message bytes seen so far
  always_comb
  begin
    lif.first_b = (r_r.cnt == 9'h000) ? RX_DATA : r_r.first;
    lif.len_b   = (r_r.cnt == 9'h001) ? RX_DATA : r_r.len;
    lif.cnt     = r_r.cnt;
    // Identify followed by ATN uses the short limit
    lif.limit   = (r_r.st == stss_pkg::ST_MSG2) ? `STSS_LIMIT_IDENT : `STSS_LIMIT_LONG;
  end

  // Handshake and phase decode
  always_comb
  begin
    RX_TAKE       = (r_r.st == stss_pkg::ST_MSG1) || (r_r.st == stss_pkg::ST_MSG2) ||
                    (r_r.st == stss_pkg::ST_CMD)  || (r_r.st == stss_pkg::ST_MSG3);
    PHASE_CMD     = (r_r.st == stss_pkg::ST_CMD);
    PHASE_MSG_OUT = RX_TAKE && !PHASE_CMD;
  end

  assign take = RX_TAKE && RX_VALID;
  assign atn  = r_r.atn_s2;
  assign blen = cdb_len(lif.first_b);

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------

  // Next state of the whole block
  always_comb
  begin
    r_nxt        = r_r;
    r_nxt.atn_s1 = ATN;
    r_nxt.atn_s2 = r_r.atn_s1;
    if (take)
    begin
      r_nxt.cnt = r_r.cnt + 9'h001;
      if (r_r.cnt == 9'h000)
        r_nxt.first = RX_DATA;
      if (r_r.cnt == 9'h001)
        r_nxt.len = RX_DATA;
    end
    unique case (r_r.st)
      stss_pkg::ST_IDLE:
      begin
        if (SELECTED)
        begin
          r_nxt.cnt   = 9'h000;
          r_nxt.ident = 1'b0;
          // (RULE5) report selection when auto response is off
          if (!AUTO_SEL_RESP)
            r_nxt = report(r_nxt, atn ? `STSS_CODE_SEL_ATN : `STSS_CODE_SEL,
                           `STSS_STEP_00);
          // (RULE14) auto response continues the sequence
          else if (atn)
            r_nxt.st = stss_pkg::ST_MSG1;
          // (RULE6) message only, no ATN at selection
          else if (MSG_ONLY)
            r_nxt = report(r_nxt, `STSS_CODE_NO_ATN, `STSS_STEP_81);
          // (RULE16) message or command setting goes to command
          else
            r_nxt.st = stss_pkg::ST_CMD;
        end
      end
      stss_pkg::ST_MSG1:
      begin
        if (take)
        begin
          if ((r_r.cnt == 9'h000) && RX_DATA[`STSS_IDENT_BIT])
          begin
            // (RULE8) illegal Identify, step from ATN
            if ((RX_DATA & `STSS_IDENT_RSVD) != 8'h00)
              r_nxt = report(r_nxt, `STSS_CODE_BAD_IDENT,
                             atn ? `STSS_STEP_82 : `STSS_STEP_92);
            else
            begin
              r_nxt.ident = 1'b1;
              r_nxt.cnt   = 9'h000;
              r_nxt.st    = atn ? stss_pkg::ST_MSG2 : stss_pkg::ST_CMD;
            end
          end
          // (RULE1) long message, stop after two bytes
          else if (lif.too_long)
            r_nxt = report(r_nxt, `STSS_CODE_LONG, `STSS_STEP_81);
          // (RULE7) single non-Identify message
          else if (lif.last)
            r_nxt = report(r_nxt, `STSS_CODE_MSG, atn ? `STSS_STEP_A3 : `STSS_STEP_A2);
        end
      end
      stss_pkg::ST_MSG2:
      begin
        if (take)
        begin
          // (RULE2) long message after Identify
          if (lif.too_long)
            r_nxt = report(r_nxt, `STSS_CODE_LONG, `STSS_STEP_82);
          // (RULE9) Identify and one more message
          else if (lif.last)
            r_nxt = report(r_nxt, `STSS_CODE_IDENT_MSG,
                           atn ? `STSS_STEP_84 : `STSS_STEP_83);
        end
      end
      stss_pkg::ST_CMD:
      begin
        if (take)
        begin
          if ((r_r.cnt == 9'h000) && (blen == 4'h0))
          begin
            // (RULE10) (RULE11) undefined opcode, one byte only
            if (r_r.ident)
              r_nxt = report(r_nxt, `STSS_CODE_IDENT_BAD, `STSS_STEP_92);
            else
              r_nxt = report(r_nxt, `STSS_CODE_BAD_CDB, `STSS_STEP_B1);
          end
          else if (r_r.cnt == {5'h00, blen - 4'h1})
          begin
            // (RULE15) ATN after block leads to message out in auto receive or after Identify
            if (atn && (AUTO_RECV || r_r.ident))
            begin
              r_nxt.cnt = 9'h000;
              r_nxt.st  = stss_pkg::ST_MSG3;
            end
            // (RULE12) complete command block
            else if (r_r.ident)
              r_nxt = report(r_nxt, `STSS_CODE_IDENT_CDB, `STSS_STEP_93);
            else
              r_nxt = report(r_nxt, `STSS_CODE_CDB, `STSS_STEP_B2);
          end
        end
      end
      stss_pkg::ST_MSG3:
      begin
        if (take)
        begin
          // (RULE3) (RULE4) long message after the block
          if (lif.too_long)
            r_nxt = report(r_nxt, `STSS_CODE_LONG,
                           r_r.ident ? `STSS_STEP_93 : `STSS_STEP_B2);
          // (RULE13) message after the block, step from ATN
          else if (lif.last)
            r_nxt = report(r_nxt, `STSS_CODE_CDB_MSG,
                           atn ? `STSS_STEP_B4 : `STSS_STEP_B1);
        end
      end
      stss_pkg::ST_RPT:
      begin
        // (RULE17) hold codes until the host reads them
        if (CODE_RD)
        begin
          r_nxt.valid = 1'b0;
          r_nxt.st    = stss_pkg::ST_IDLE;
        end
      end
      default:
        r_nxt = RST_VAL;  // Illegal state code recovers to idle
    endcase
  end

  // Register the state
  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      r_r <= RST_VAL;
    else
      r_r <= r_nxt;
  end

  assign INT_CODE  = r_r.code;
  assign SEQ_STEP  = r_r.step;
  assign INT_VALID = r_r.valid;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  logic idle_sel;  // Selection taken in idle
  assign idle_sel = (r_r.st == stss_pkg::ST_IDLE) && SELECTED;

  // (RULE5) selection without auto response
  chk_sel_no_auto: assert property ( // (RULE5)
    idle_sel && !AUTO_SEL_RESP |=> INT_VALID && SEQ_STEP == 8'h00 &&
      INT_CODE == ($past(atn) ? 8'h81 : 8'h80))
    else $error("selection code wrong");

  // (RULE14) auto response never stops at selection with ATN
  chk_auto_continue: assert property ( // (RULE14)
    idle_sel && AUTO_SEL_RESP && atn |=> !INT_VALID ##0 PHASE_MSG_OUT)
    else $error("auto response stopped early");

  // (RULE6) message only without ATN
  chk_msg_only: assert property ( // (RULE6)
    idle_sel && AUTO_SEL_RESP && !atn && MSG_ONLY |=>
      INT_CODE == 8'hA0 && SEQ_STEP == 8'h81)
    else $error("message only code wrong");

  // (RULE1) long first message stops at its second byte
  chk_long_first: assert property ( // (RULE1)
    take && r_r.st == stss_pkg::ST_MSG1 && r_r.cnt == 9'h001 && lif.too_long |=>
      INT_VALID && INT_CODE == 8'h67 && SEQ_STEP == 8'h81 && !RX_TAKE)
    else $error("long message not stopped");

  // (RULE10) undefined first opcode takes one byte
  chk_bad_opcode: assert property ( // (RULE10)
    take && PHASE_CMD && r_r.cnt == 9'h000 && blen == 4'h0 && !r_r.ident |=>
      INT_CODE == 8'hA4 && SEQ_STEP == 8'hB1 && !RX_TAKE)
    else $error("undefined opcode not stopped");

  // (RULE17) codes stay put while pending and unread
  chk_codes_hold: assert property ( // (RULE17)
    INT_VALID && !CODE_RD |=> INT_VALID && $stable(INT_CODE) && $stable(SEQ_STEP))
    else $error("codes changed before read");

  // (RULE12) block codes pair with their steps
  chk_block_pair: assert property ( // (RULE12)
    $rose(INT_VALID) && (INT_CODE == 8'hA6 || INT_CODE == 8'hA7) |->
      SEQ_STEP == (INT_CODE == 8'hA6 ? 8'hB2 : 8'h93))
    else $error("block step wrong");

  // (RULE13) message after block reports B1h or B4h
  chk_cdb_msg: assert property ( // (RULE13)
    $rose(INT_VALID) && INT_CODE == 8'hA8 |->
      SEQ_STEP == ($past(atn) ? 8'hB4 : 8'hB1))
    else $error("message after block step wrong");

  // (RULE8) illegal Identify step follows ATN
  chk_bad_ident: assert property ( // (RULE8)
    $rose(INT_VALID) && INT_CODE == 8'hA2 |->
      SEQ_STEP == ($past(atn) ? 8'h82 : 8'h92))
    else $error("illegal identify step wrong");

  // (RULE9) Identify plus message step follows ATN
  chk_ident_msg: assert property ( // (RULE9)
    $rose(INT_VALID) && INT_CODE == 8'hA3 |->
      SEQ_STEP == ($past(atn) ? 8'h84 : 8'h83))
    else $error("identify message step wrong");

  // (RULE17) read returns the block to idle in one cycle
  chk_read_idle: assert property ( // (RULE17)
    INT_VALID && CODE_RD |=> !INT_VALID && !RX_TAKE ##1 (!INT_VALID || $past(SELECTED)))
    else $error("read did not clear");

endmodule

// *** verification/stss_initiator.sv ***
/*
  Initiator model: offers queued bytes, each with the ATN level it wants
  seen when that byte is taken; counts taken bytes.
  Assumes the bench fills q, sets sel_atn and slow, and clears taken.
*/
`timescale 1ns/1ps

module stss_initiator (
  input  wire logic       clk,       // Core clock
  input  wire logic       rx_take,   // Target accepts bytes
  input  wire logic       ph_msg,    // Message out phase wanted
  input  wire logic       ph_cmd,    // Command phase wanted
  output logic            atn,       // ATN pin
  output logic            rx_valid,  // Byte offered
  output logic [7:0]      rx_data    // Offered byte
);
  logic [8:0] q [$];     // Queued bytes, bit 8 is ATN
  logic       sel_atn;   // ATN level while nothing queued
  logic       slow;      // Pause after every taken byte
  logic       hit;       // Byte taken at last edge
  logic [1:0] first_ph;  // Phases seen at first take
  logic       nxt;       // ATN level wanted now
  int         taken;     // Bytes taken so far
  int         calm;      // Cycles ATN has stood

  // Idle values at time zero
  initial
  begin
    atn = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    sel_atn = 1'b0;
    slow = 1'b0;
    hit = 1'b0;
    first_ph = 2'h0;
    taken = 0;
    calm = 0;
  end

  // Note each take and the phase of the first one
  always @(posedge clk)
  begin
    hit <= rx_valid && rx_take;
    if (rx_valid && rx_take && taken == 0)
      first_ph <= {ph_msg, ph_cmd};
  end

  // Drop the taken byte; ATN settles 3 cycles before a byte is offered,
  // since the target sees the pin two edges late
  always @(negedge clk)
  begin
    if (hit && q.size() > 0)
    begin
      void'(q.pop_front());
      taken = taken + 1;
    end
    nxt = (q.size() > 0) ? q[0][8] : sel_atn;
    calm = (nxt != atn || (hit && slow)) ? 0 : calm + 1;
    atn = nxt;
    rx_valid = (q.size() > 0) && (calm >= 3);
    // Released data flips every cycle
    rx_data = rx_valid ? q[0][7:0] : ~rx_data;
  end
endmodule

// *** verification/test_scsi_target_select_status.sv ***
/*
  Testbench of the target selection status reporter: a table of post
  selection sequences, then reset, refusal and recovery cases.
  Assumes the initiator model stss_initiator and a 40 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

module test_scsi_target_select_status;
  // ------------------------------------------------------------------
  // Signals and sequence table
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cfg;    // Auto response, auto receive, message only
    logic       atn;    // ATN at selection
    logic [9:0] id;     // Identify: present, ATN, byte
    logic [9:0] cdb;    // Opcode: present, ATN, byte
    logic [9:0] m0;     // Message first byte
    logic [9:0] m1;     // Message second byte
    logic [7:0] code;   // Expected interrupt code
    logic [7:0] step;   // Expected step code
    logic [7:0] taken;  // Expected bytes taken
  } stss_row_t;

  localparam logic [9:0] NO = 10'h000;  // Unit absent
  logic       clk, arst_n, auto_sel, auto_recv, msg_only, selected, code_rd;
  logic       atn, rx_valid, rx_take, ph_msg, ph_cmd, int_valid;
  logic [7:0] rx_data, int_code, seq_step;
  int         errors, checked;

  stss_row_t rows [21] = '{
    '{3'b000, 1'b0, NO, NO, NO, NO, 8'h80, 8'h00, 8'h00},
    '{3'b000, 1'b1, NO, NO, NO, NO, 8'h81, 8'h00, 8'h00},
    '{3'b101, 1'b0, NO, NO, NO, NO, 8'hA0, 8'h81, 8'h00},
    '{3'b100, 1'b1, NO, NO, 10'h301, 10'h31F, 8'h67, 8'h81, 8'h02},
    '{3'b100, 1'b1, 10'h380, NO, 10'h301, 10'h301, 8'h67, 8'h82, 8'h03},
    '{3'b100, 1'b1, 10'h280, 10'h320, 10'h301, 10'h31F, 8'h67, 8'h93, 8'h0D},
    '{3'b110, 1'b0, NO, 10'h3A0, 10'h301, 10'h320, 8'h67, 8'hB2, 8'h0E},
    '{3'b100, 1'b1, NO, NO, 10'h206, NO, 8'hA1, 8'hA2, 8'h01},
    '{3'b100, 1'b1, NO, NO, 10'h306, NO, 8'hA1, 8'hA3, 8'h01},
    '{3'b100, 1'b1, 10'h298, NO, NO, NO, 8'hA2, 8'h92, 8'h01},
    '{3'b100, 1'b1, 10'h398, NO, NO, NO, 8'hA2, 8'h82, 8'h01},
    '{3'b100, 1'b1, 10'h380, NO, 10'h206, NO, 8'hA3, 8'h83, 8'h02},
    '{3'b100, 1'b1, 10'h380, NO, 10'h306, NO, 8'hA3, 8'h84, 8'h02},
    '{3'b100, 1'b0, NO, 10'h2E0, NO, NO, 8'hA4, 8'hB1, 8'h01},
    '{3'b100, 1'b1, 10'h280, 10'h260, NO, NO, 8'hA5, 8'h92, 8'h02},
    '{3'b100, 1'b0, NO, 10'h200, NO, NO, 8'hA6, 8'hB2, 8'h06},
    '{3'b100, 1'b1, 10'h280, 10'h200, NO, NO, 8'hA7, 8'h93, 8'h07},
    // without Identify, message after block only in auto receive
    '{3'b110, 1'b0, NO, 10'h300, 10'h206, NO, 8'hA8, 8'hB1, 8'h07},
    '{3'b110, 1'b0, NO, 10'h300, 10'h306, NO, 8'hA8, 8'hB4, 8'h07},
    '{3'b100, 1'b0, NO, 10'h300, NO, NO, 8'hA6, 8'hB2, 8'h06},
    // message only setting with ATN continues
    '{3'b101, 1'b1, NO, NO, 10'h206, NO, 8'hA1, 8'hA2, 8'h01}
  };

  stss_top DUT (
    .CORE_CLK(clk), .ARST_N(arst_n), .AUTO_SEL_RESP(auto_sel), .AUTO_RECV(auto_recv),
    .MSG_ONLY(msg_only), .SELECTED(selected), .ATN(atn), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .CODE_RD(code_rd), .RX_TAKE(rx_take), .PHASE_MSG_OUT(ph_msg),
    .PHASE_CMD(ph_cmd), .INT_CODE(int_code), .SEQ_STEP(seq_step), .INT_VALID(int_valid)
  );

  stss_initiator ini (
    .clk(clk), .rx_take(rx_take), .ph_msg(ph_msg), .ph_cmd(ph_cmd),
    .atn(atn), .rx_valid(rx_valid), .rx_data(rx_data)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  // Block length by opcode group; undefined gets 4 to catch over-take
  function automatic int cdb_len(input logic [7:0] op);
    case (op[7:5])
      3'h0: cdb_len = 6;
      3'h1, 3'h2: cdb_len = 10;
      3'h5: cdb_len = 12;
      default: cdb_len = 4;
    endcase
  endfunction

  // Queue a unit: its first byte, then filler with the same ATN
  task automatic push(input logic [9:0] b, input int n);
    if (b[9])
    begin
      ini.q.push_back(b[8:0]);
      repeat (n - 1) ini.q.push_back({b[8], 8'h00});
    end
  endtask

  // Select, feed the sequence, check the held result, then read it
  task automatic run_row(input stss_row_t r, input logic slow);
    int n;
    {auto_sel, auto_recv, msg_only} = r.cfg;
    ini.sel_atn = r.atn;
    ini.slow = slow;
    ini.taken = 0;
    repeat (4) @(negedge clk);
    selected = 1'b1;
    @(negedge clk);
    selected = 1'b0;
    push(r.id, 1);
    push(r.cdb, cdb_len(r.cdb[7:0]));
    push(r.m0, 1);
    push(r.m1, 3);
    n = 0;
    while (int_valid !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    `CHK({int_code, seq_step}, {r.code, r.step})
    // Let an edge pass before the refused selection pulse
    @(negedge clk);
    selected = 1'b1;
    @(negedge clk);
    selected = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({int_valid, int_code, seq_step}, {1'b1, r.code, r.step})
    `CHK(ini.taken, r.taken)
    if (r.taken != 0) `CHK(ini.first_ph, r.atn ? 2'b10 : 2'b01)
    code_rd = 1'b1;
    @(negedge clk);
    code_rd = 1'b0;
    `CHK({int_valid, rx_take}, 2'b00)
    ini.q.delete();
    @(negedge clk);
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Sequence of tests
  // ------------------------------------------------------------------
  initial
  begin
    int n;
    clk = 1'b0;
    arst_n = 1'b0;
    {auto_sel, auto_recv, msg_only, selected, code_rd} = 5'h00;
    errors = 0;
    checked = 0;
    repeat (16) @(negedge clk);
    `CHK({int_valid, int_code, seq_step, rx_take, ph_msg, ph_cmd}, 20'h00000)
    arst_n = 1'b1;
    for (int i = 0; i < 21; i++) run_row(rows[i], i[0]);
    // Reset in the middle of a command block
    {auto_sel, auto_recv, msg_only} = 3'b100;
    ini.sel_atn = 1'b0;
    ini.taken = 0;
    repeat (4) @(negedge clk);
    selected = 1'b1;
    @(negedge clk);
    selected = 1'b0;
    push(10'h200, 6);
    n = 0;
    while (ini.taken < 2 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    // A block that never starts counts as a mismatch
    if (n >= 100) errors++;
    arst_n = 1'b0;
    #1;
    `CHK({int_valid, rx_take, int_code}, 10'h000)
    ini.q.delete();
    ini.taken = 0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    // Bytes offered while idle stay untaken
    push(10'h206, 1);
    repeat (8) @(negedge clk);
    `CHK(ini.taken, 0)
    ini.q.delete();
    run_row(rows[15], 1'b0);
    print_verdict();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
